// [dv/can_rx_overwrite_and_filter_mask_bench.sv]
// bench for the receive status block
`timescale 1ns/1ps
`default_nettype none
module can_rx_overwrite_and_filter_mask_bench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        unread_irq_flag, mb0_ext, tx_err, tx_ok;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [28:0] mb0_id;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [15:0] receive_pending_flags;
  crx_pkg::crx_rx_evt_t rx_evt;
  crx_pkg::crx_store_t  store;
  logic [33:0] rq[$];
  logic [1:0]  wq[$];
  int          fail_count = 0;
  int          n_tests = 0;
  logic [7:0]  offs[5] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h08};
  logic [15:0] mval[5] = '{16'h8000, 16'h0001, 16'h8000, 16'h0200, 16'h0080};
  int          bitn[5] = '{7, 8, 20, 17, 28};
  crx_top #(.TEC_W(9)) dut_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .rx_evt, .mb0_id, .mb0_ext, .tx_err, .tx_ok, .store,
    .receive_pending_flags, .unread_irq_flag, .irq);
  crx_node node_u (.aclk, .rx_evt, .tx_err, .tx_ok);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    wq.push_back(a > 8'h14 ? 2'h2 : 2'h0);
    s_axi_awaddr <= a;
    s_axi_awprot <= 3'($urandom);
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d);
    rq.push_back({a > 8'h14 ? 2'h2 : 2'h0, 16'h0, d});
    s_axi_araddr <= a;
    s_axi_arprot <= 3'($urandom);
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata},
      rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, wq.pop_front());
  end
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    summarize();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, aresetn} = 4'h0;
    {s_axi_bready, s_axi_rready, mb0_ext} = 3'h7;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
    void'($urandom(30137));
    mb0_id = 29'($urandom);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h08, 16'h0000);
    rd(8'h14, 16'hFFFF);
    rd(8'h18, 16'h0000);
    wr(8'h08, 16'hFFFF);
    rd(8'h08, 16'hE3FF);
    s_axi_wstrb <= 4'h2;
    wr(8'h04, 16'hFFFF);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 16'hFF00);
    wr(8'h04, 16'h0000);
    $display("test registers done");
    node_u.frame(4'h0, mb0_id, 1'b0);
    rd(8'h10, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      wr(offs[k], mval[k]);
      node_u.frame(4'h0, mb0_id ^ (29'h1 << bitn[k]), 1'b1);
      rd(8'h10, 16'h0100);
      wr(8'h10, 16'h0100);
      wr(offs[k], 16'h0000);
      node_u.frame(4'h0, mb0_id ^ (29'h1 << bitn[k]), 1'b1);
      rd(8'h10, 16'h0000);
    end
    $display("test filter done");
    for (int k = 0; k < 2; k++) begin
      node_u.frame(4'h3, 29'($urandom), 1'b1);
      node_u.frame(4'hB, 29'($urandom), 1'b0);
      node_u.frame(4'h0, mb0_id, 1'b1);
    end
    rd(8'h00, 16'h0908);
    chk(irq, 0);
    wr(8'h14, 16'hF7FF);
    chk(irq, 1);
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h0800);
    rd(8'h00, 16'h0108);
    chk(irq, 0);
    $display("test overwrite done");
    node_u.txres(1'b0);
    node_u.txres(1'b1);
    node_u.txres(1'b1);
    node_u.txres(1'b0);
    rd(8'h0C, 16'h000F);
    $display("test counter done");
    summarize();
  end
endmodule // can_rx_overwrite_and_filter_mask_bench
bind crx_top crx_props #(.TEC_W(TEC_W)) u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .rx_evt, .mb0_ext, .store,
  .receive_pending_flags, .unread_irq_flag, .irq);
`default_nettype wire

// [dv/crx_node.sv]
// far-side bus nodes: received frames and transmit outcomes
`timescale 1ns/1ps
`default_nettype none
module crx_node (
  input  wire logic            aclk,
  output crx_pkg::crx_rx_evt_t rx_evt,
  output logic                 tx_err,
  output logic                 tx_ok
);
  initial begin
    rx_evt = '0;
    tx_err = 1'b0;
    tx_ok = 1'b0;
  end
  // one frame end; fields turned over once released
  task automatic frame(input logic [3:0] m, input logic [28:0] i,
                       input logic e);
    rx_evt <= '{1'b1, m, i, e};
    @(posedge aclk);
    rx_evt <= '{1'b0, ~m, ~i, ~e};
    @(posedge aclk);
  endtask
  task automatic txres(input logic e);
    tx_err <= e;
    tx_ok <= !e;
    @(posedge aclk);
    tx_err <= 1'b0;
    tx_ok <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // crx_node
`default_nettype wire

// [dv/crx_props.sv]
// checker on the receive status block ports
`timescale 1ns/1ps
`default_nettype none
module crx_props #(parameter int TEC_W = 9) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_wvalid,
  input wire crx_pkg::crx_rx_evt_t rx_evt,
  input wire logic                 mb0_ext,
  input wire crx_pkg::crx_store_t  store,
  input wire logic [15:0]          receive_pending_flags,
  input wire logic                 unread_irq_flag,
  input wire logic                 irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire quiet = !s_axi_awvalid && !s_axi_wvalid;
  sequence s_evt;
    rx_evt.valid && rx_evt.mbox != 4'h0;
  endsequence
  sequence s_mb0;
    rx_evt.valid && rx_evt.mbox == 4'h0;
  endsequence
  chk_store_slot: assert property (s_evt |=> store.valid &&
    store.mbox == $past(rx_evt.mbox)) else $error("bad store");
  chk_store_once: assert property (s_evt ##1 !rx_evt.valid
    |=> !store.valid) else $error("long store");
  chk_pend_set: assert property (s_evt |=>
    receive_pending_flags[$past(rx_evt.mbox)]) else $error("no pend");
  chk_ovw_set: assert property (s_evt
    ##0 receive_pending_flags[rx_evt.mbox] |=> unread_irq_flag)
    else $error("no flag");
  chk_ovw_hold: assert property (quiet && $past(quiet)
    && unread_irq_flag |=> unread_irq_flag) else $error("flag lost");
  chk_irq_gate: assert property (irq |-> unread_irq_flag)
    else $error("stray irq");
  chk_fmt_reject: assert property (s_mb0 ##0 rx_evt.ext != mb0_ext
    |=> !store.valid) else $error("bad accept");
  chk_no_spur: assert property (store.valid |-> $past(rx_evt.valid))
    else $error("stray store");
endmodule // crx_props
`default_nettype wire

// [rtl/crx_pkg.sv]
// types of the receive status block
package crx_pkg;

  typedef struct packed {
    logic        valid;
    logic [3:0]  mbox;
    logic [28:0] id;
    logic        ext;
  } crx_rx_evt_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  mbox;
  } crx_store_t;

  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] ovw;
    logic [15:0] mask_lo;
    logic [15:0] mask_hi;
    logic [15:0] pend;
    logic [15:0] imask;
    logic [8:0]  transmit_error_counter;
    logic        store_v;
    logic [3:0]  store_mb;
  } crx_state_t;

endpackage

// [rtl/crx_regs.svh]
// register offsets, reset values and counts of the receive status block
`ifndef CRX_REGS_SVH
`define CRX_REGS_SVH

`define CRX_OFF_OVW       8'h00
`define CRX_OFF_MASK_LO   8'h04
`define CRX_OFF_MASK_HI   8'h08
`define CRX_OFF_TEC       8'h0C
`define CRX_OFF_PEND      8'h10
`define CRX_OFF_IMASK     8'h14

`define CRX_RST_OVW       16'h0000
`define CRX_RST_MASK_LO   16'h0000
`define CRX_RST_MASK_HI   16'h0000
`define CRX_RST_PEND      16'h0000
`define CRX_RST_IMASK     16'hFFFF

`define CRX_MASK_HI_RSVD  16'h1C00
`define CRX_STD_DONTCARE  29'h0003FFFF

`define CRX_TEC_ERR_STEP  8
`define CRX_TEC_OK_STEP   1

`define CRX_RESP_OKAY     2'h0
`define CRX_RESP_SLVERR   2'h2

`endif

// [rtl/crx_top.sv]
// receive overwrite flags, mailbox 0 acceptance masks, transmit error count
`include "crx_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module crx_top #(
  parameter int TEC_W = 9
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  input  wire crx_pkg::crx_rx_evt_t rx_evt,
  input  wire logic [28:0]          mb0_id,
  input  wire logic                 mb0_ext,
  input  wire logic                 tx_err,
  input  wire logic                 tx_ok,
  output crx_pkg::crx_store_t       store,
  output logic [15:0]               receive_pending_flags,
  output logic                      unread_irq_flag,
  output logic                      irq
);

  crx_pkg::crx_state_t s_r;
  crx_pkg::crx_state_t s_nxt;

  // shared decode terms
  logic [15:0]    lane_mask;
  logic [15:0]    wr_data;
  logic           wr_fire;
  logic           wr_to_ovw;
  logic           wr_to_pend;
  logic [15:0]    ovw_clr;
  logic [15:0]    pend_clr;
  logic [15:0]    ovw_nxt;
  logic [15:0]    pend_nxt;
  logic [15:0]    mb_sel;
  logic [15:0]    set_pend;
  logic [15:0]    set_ovw;
  logic [28:0]    id_dontcare;
  logic [28:0]    id_match;
  logic           mb0_accept;
  logic           evt_accept;
  logic [TEC_W:0] tec_sum;
  logic           rd_fire;
  logic [31:0]    rd_word;
  logic [1:0]     rd_resp;
  logic [15:0]    ovw_view;
  logic [15:0]    pend_view;

  // counter steps
  localparam logic [TEC_W:0] TEC_UP   = (TEC_W+1)'(`CRX_TEC_ERR_STEP);
  localparam logic [TEC_W:0] TEC_DOWN = (TEC_W+1)'(`CRX_TEC_OK_STEP);
  localparam logic [TEC_W:0] TEC_MAX  = {1'b0, {TEC_W{1'b1}}};

  function automatic logic [15:0] swap_bytes(input logic [15:0] v);
    swap_bytes = {v[7:0], v[15:8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register views and bus handshakes

  assign ovw_view   = swap_bytes(s_r.ovw);
  assign pend_view  = swap_bytes(s_r.pend);
  assign wr_fire    = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_to_ovw  = wr_fire && (s_r.awaddr == `CRX_OFF_OVW);
  assign wr_to_pend = wr_fire && (s_r.awaddr == `CRX_OFF_PEND);
  assign rd_fire    = s_axi_arvalid && s_axi_arready;
  assign ovw_clr    = wr_to_ovw ? swap_bytes(wr_data)
                                : 16'h0000;
  assign pend_clr   = wr_to_pend ? swap_bytes(wr_data)
                                 : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // byte lanes

  for (genvar b = 0; b < 16; b++) begin : g_lane
    assign lane_mask[b] = s_r.wstrb[b / 8];
  end
  assign wr_data = s_r.wdata & lane_mask;

  ////////////////////////////////////////////////////////////////////////////
  // per mailbox flags

  for (genvar n = 0; n < 16; n++) begin : g_mbox
    assign mb_sel[n]   = (rx_evt.mbox == 4'(n));
    assign set_pend[n] = evt_accept && mb_sel[n];
    assign set_ovw[n]  = set_pend[n] && s_r.pend[n];
    // set wins over a same cycle clear
    assign ovw_nxt[n]  = set_ovw[n] || (s_r.ovw[n] && !ovw_clr[n]);
    assign pend_nxt[n] = set_pend[n] || (s_r.pend[n] && !pend_clr[n]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // mailbox 0 acceptance

  always_comb begin
    id_dontcare = {s_r.mask_hi[7:0], s_r.mask_hi[15:13], s_r.mask_hi[9:8],
                   s_r.mask_lo[7:0], s_r.mask_lo[15:8]};
    if (!rx_evt.ext) begin
      id_dontcare = id_dontcare | `CRX_STD_DONTCARE;
    end
    id_match   = ~(rx_evt.id ^ mb0_id) | id_dontcare;
    mb0_accept = (&id_match) && (rx_evt.ext == mb0_ext);
    if (mb_sel[0]) begin
      evt_accept = rx_evt.valid && mb0_accept;
    end else begin
      evt_accept = rx_evt.valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit error counter, saturating both ways

  always_comb begin
    tec_sum = {1'b0, s_r.transmit_error_counter[TEC_W-1:0]};
    if (tx_err) begin
      tec_sum = tec_sum + TEC_UP;
      if (tec_sum[TEC_W]) begin
        tec_sum = TEC_MAX;
      end
    end else if (tx_ok && tec_sum != '0) begin
      tec_sum = tec_sum - TEC_DOWN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data select

  always_comb begin
    rd_word = '0;
    rd_resp = `CRX_RESP_OKAY;
    case (s_axi_araddr)
      `CRX_OFF_OVW: begin
        rd_word[15:0] = ovw_view;
      end
      `CRX_OFF_MASK_LO: begin
        rd_word[15:0] = s_r.mask_lo;
      end
      `CRX_OFF_MASK_HI: begin
        rd_word[15:0] = s_r.mask_hi & ~`CRX_MASK_HI_RSVD;
      end
      `CRX_OFF_TEC: begin
        rd_word[TEC_W-1:0] = s_r.transmit_error_counter[TEC_W-1:0];
      end
      `CRX_OFF_PEND: begin
        rd_word[15:0] = pend_view;
      end
      `CRX_OFF_IMASK: begin
        rd_word[15:0] = s_r.imask;
      end
      default: begin
        rd_resp = `CRX_RESP_SLVERR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] wm;
    logic [15:0] wd;
    wm     = lane_mask;
    wd     = wr_data;
    s_nxt  = s_r;

    // write address and data, either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata[15:0];
      s_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // register write, software clears before hardware sets
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = `CRX_RESP_OKAY;
      case (s_r.awaddr)
        `CRX_OFF_OVW: begin
        end
        `CRX_OFF_MASK_LO: begin
          s_nxt.mask_lo = (s_r.mask_lo & ~wm) | wd;
        end
        `CRX_OFF_MASK_HI: begin
          s_nxt.mask_hi = ((s_r.mask_hi & ~wm) | wd)
                          & ~`CRX_MASK_HI_RSVD;
        end
        `CRX_OFF_TEC: begin
        end
        `CRX_OFF_PEND: begin
        end
        `CRX_OFF_IMASK: begin
          s_nxt.imask = (s_r.imask & ~wm) | wd;
        end
        default: begin
          s_nxt.bresp = `CRX_RESP_SLVERR;
        end
      endcase
    end

    // register read
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = rd_resp;
      s_nxt.rdata  = rd_word;
    end

    ////////////////////////////////////////////////////////////////////////
    // reception end: store, pending, overwrite; set wins over clear
    s_nxt.store_v  = evt_accept;
    s_nxt.store_mb = rx_evt.mbox;
    s_nxt.ovw      = ovw_nxt;
    s_nxt.pend     = pend_nxt;

    // transmit error counter
    s_nxt.transmit_error_counter = 9'(tec_sum[TEC_W-1:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.ovw     <= `CRX_RST_OVW;
      s_r.mask_lo <= `CRX_RST_MASK_LO;
      s_r.mask_hi <= `CRX_RST_MASK_HI;
      s_r.pend    <= `CRX_RST_PEND;
      s_r.imask   <= `CRX_RST_IMASK;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs

  assign s_axi_awready         = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready          = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid          = s_r.bvalid;
  assign s_axi_bresp           = s_r.bresp;
  assign s_axi_arready         = !s_r.rvalid;
  assign s_axi_rvalid          = s_r.rvalid;
  assign s_axi_rdata           = s_r.rdata;
  assign s_axi_rresp           = s_r.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // receive side outputs

  assign store.valid           = s_r.store_v;
  assign store.mbox            = s_r.store_mb;
  assign receive_pending_flags = s_r.pend;
  assign unread_irq_flag       = |s_r.ovw;
  assign irq = |(ovw_view & ~s_r.imask);

endmodule // crx_top

`default_nettype wire
